// ==== rtl/pd_pkg.sv ====
// Shared constants for the power-down gate link and its two ends
package pd_pkg;
  // ============================================================
  // Clock and link
  localparam int SYS_PERIOD_PS = 5000;
  localparam int CK_HALF_DEFAULT = 12;
  localparam int CA_W = 6;
  // ============================================================
  // Link timing, analog part in ps, clock part in link cycles
  localparam int CMD_TO_GATE_PS = 1750;
  localparam int CMD_TO_GATE_NCK = 3;
  localparam int CLOCK_HOLD_PS = 5000;
  localparam int CLOCK_HOLD_NCK = 5;
  localparam int SELECT_HOLD_PS = 5000;
  localparam int SELECT_HOLD_NCK = 5;
  localparam int MIN_PULSE_PS = 7500;
  localparam int MIN_PULSE_NCK = 4;
  localparam int CLOCK_PRE_PS = 1750;
  localparam int CLOCK_PRE_NCK = 3;
  localparam int EXIT_LAT_PS = 7500;
  localparam int EXIT_LAT_NCK = 5;
  localparam int SHORT_POST_NCK = 1;
  localparam int LONG_POST_NCK = 2;
  // ============================================================
  // Controller register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_PD_REQ = 0;
  localparam int CTRL_DRAM_RESET = 1;
  localparam int CTRL_LONG_POST = 2;
  localparam int CTRL_OP_BUSY = 3;
  localparam int CTRL_OSC_RUN = 4;
  localparam int CMD_IS_MRR = 8;
  localparam int STAT_GATE_LOW = 0;
  localparam int STAT_PD = 1;
  localparam int STAT_CMD_PEND = 2;
  localparam int STAT_EXIT_BUSY = 3;
  // ============================================================
  // Device mode register fields
  localparam int TERM_LSB = 4;
  localparam int TERM_MSB = 6;
  localparam int SE_CLOCK_BIT = 3;
  localparam int SE_WSTROBE_BIT = 2;
  localparam int SE_RSTROBE_BIT = 1;
  localparam logic [1:0] PD_IDLE = 2'h0;
  localparam logic [1:0] PD_ACTIVE = 2'h1;
  localparam logic [1:0] PD_SELF_REFRESH = 2'h2;
  localparam int TIMER_W = 12;

  // Least sys cycles covering both ps and link cycles
  function automatic logic [TIMER_W-1:0] hold_cycles(input int ps, input int nck, input int half);
    int a;
    int b;
    a = (ps + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    b = nck * 2 * half;
    if (a < 1) a = 1;
    hold_cycles = (a > b) ? a[TIMER_W-1:0] : b[TIMER_W-1:0];
  endfunction : hold_cycles
endpackage : pd_pkg

// ==== rtl/pd_link_if.sv ====
// Gate, select, command and clock link between controller and device
`timescale 1ns/100ps
interface pd_link_if;
  import pd_pkg::*;
  logic gate;
  logic sel;
  logic [CA_W-1:0] ca;
  logic ck;
  logic reset_n;
  modport ctrl (output gate, output sel, output ca, output ck, output reset_n);
  modport dram (input gate, input sel, input ca, input ck, input reset_n);
endinterface : pd_link_if

// ==== rtl/pd_controller.sv ====
// Memory controller end: gate sequencing, link clock and Avalon-MM registers
`timescale 1ns/100ps
module pd_controller import pd_pkg::*; #(
  parameter int CK_HALF = CK_HALF_DEFAULT,
  parameter int READ_LATENCY = 6,
  parameter int READ_STROBE_DELAY_PS = 3600,
  parameter int BURST_LENGTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  pd_link_if.ctrl link
);
  // ============================================================
  // Derived waits
  localparam logic [TIMER_W-1:0] T_CMD_GATE = hold_cycles(CMD_TO_GATE_PS, CMD_TO_GATE_NCK, CK_HALF);
  localparam logic [TIMER_W-1:0] T_ENTRY_HOLD_A = hold_cycles(SELECT_HOLD_PS, SELECT_HOLD_NCK, CK_HALF);
  localparam logic [TIMER_W-1:0] T_ENTRY_HOLD_B = hold_cycles(CLOCK_HOLD_PS, CLOCK_HOLD_NCK, CK_HALF);
  localparam logic [TIMER_W-1:0] T_PULSE = hold_cycles(MIN_PULSE_PS, MIN_PULSE_NCK, CK_HALF);
  localparam logic [TIMER_W-1:0] T_CLK_PRE = hold_cycles(CLOCK_PRE_PS, CLOCK_PRE_NCK, CK_HALF);
  localparam logic [TIMER_W-1:0] T_EXIT_A = hold_cycles(EXIT_LAT_PS, EXIT_LAT_NCK, CK_HALF);
  localparam int MRR_NCK = READ_LATENCY + BURST_LENGTH / 2;
  localparam logic [TIMER_W-1:0] T_MRR_SHORT =
    TIMER_W'((MRR_NCK + SHORT_POST_NCK) * 2 * CK_HALF + (READ_STROBE_DELAY_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [TIMER_W-1:0] T_MRR_LONG =
    TIMER_W'((MRR_NCK + LONG_POST_NCK) * 2 * CK_HALF + (READ_STROBE_DELAY_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
  localparam logic [TIMER_W-1:0] T_HOLD_AB = (T_ENTRY_HOLD_A > T_ENTRY_HOLD_B) ? T_ENTRY_HOLD_A : T_ENTRY_HOLD_B;
  localparam logic [TIMER_W-1:0] T_HOLD = (T_HOLD_AB > T_PULSE) ? T_HOLD_AB : T_PULSE;
  localparam logic [TIMER_W-1:0] T_EXIT = (T_EXIT_A > T_PULSE) ? T_EXIT_A : T_PULSE;
  localparam logic [TIMER_W-1:0] HALF_LAST = TIMER_W'(CK_HALF - 1);

  typedef enum logic [4:0] {
    ST_RUN = 5'b0_0001,
    ST_HOLD = 5'b0_0010,
    ST_PD = 5'b0_0100,
    ST_PRE = 5'b0_1000,
    ST_EXIT = 5'b1_0000
  } ctrl_state_t;

  // ============================================================
  // Register and link state
  ctrl_state_t state_r, state_nxt;
  logic [TIMER_W-1:0] timer_r, timer_nxt;
  logic [TIMER_W-1:0] div_r, div_nxt;
  logic ck_r, ck_nxt;
  logic gate_r, gate_nxt;
  logic sel_r, sel_nxt;
  logic [CA_W-1:0] ca_r, ca_nxt;
  logic [4:0] ctrl_r, ctrl_nxt;
  logic pend_r, pend_nxt;
  logic pend_mrr_r, pend_mrr_nxt;
  logic sent_mrr_r, sent_mrr_nxt;
  logic [CA_W-1:0] pend_ca_r, pend_ca_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rstn_r, rstn_nxt;
  logic ck_fall;
  logic clk_run;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = (timer_r != '0) ? timer_r - 1'b1 : timer_r;
    div_nxt = div_r;
    ck_nxt = ck_r;
    gate_nxt = gate_r;
    sel_nxt = sel_r;
    ca_nxt = ca_r;
    ctrl_nxt = ctrl_r;
    pend_nxt = pend_r;
    pend_mrr_nxt = pend_mrr_r;
    sent_mrr_nxt = sent_mrr_r;
    pend_ca_nxt = pend_ca_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    // Clock stops only in the settled power-down state
    clk_run = (state_r != ST_PD);
    ck_fall = 1'b0;
    if (clk_run) begin
      if (div_r == HALF_LAST) begin
        div_nxt = '0;
        ck_nxt = ~ck_r;
        ck_fall = ck_r;
      end else begin
        div_nxt = div_r + 1'b1;
      end
    end else begin
      div_nxt = '0;
      ck_nxt = 1'b0;
    end
    // Avalon slave: one wait cycle (more while a command write finds one pending), then a single answer cycle
    if ((avs_read || avs_write) && wait_r) begin
      if (!(avs_write && avs_address == REG_CMD && pend_r)) begin
        wait_nxt = 1'b0;
        case (avs_address)
          REG_CTRL: rdata_nxt = {27'h000_0000, ctrl_r};
          REG_STATUS: rdata_nxt = {28'h000_0000, (state_r == ST_EXIT), pend_r, (state_r == ST_PD), ~gate_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end else if (!wait_r && avs_write) begin
      case (avs_address)
        REG_CTRL: ctrl_nxt = avs_writedata[CTRL_OSC_RUN:CTRL_PD_REQ];
        REG_CMD: begin
          pend_nxt = 1'b1;
          pend_ca_nxt = avs_writedata[CA_W-1:0];
          pend_mrr_nxt = avs_writedata[CMD_IS_MRR];
        end
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    case (state_r)
      ST_RUN: begin
        if (ck_fall && sel_r) begin
          sel_nxt = 1'b0;
          // Gate must not fall before the read has drained
          timer_nxt = !sent_mrr_r ? T_CMD_GATE : (ctrl_r[CTRL_LONG_POST] ? T_MRR_LONG : T_MRR_SHORT);
        end else if (ck_fall && pend_r) begin
          sel_nxt = 1'b1;
          ca_nxt = pend_ca_r;
          sent_mrr_nxt = pend_mrr_r;
          pend_nxt = 1'b0;
        end else if (ctrl_r[CTRL_PD_REQ] && !pend_r && !sel_r && timer_r == '0
                     && !ctrl_r[CTRL_OP_BUSY] && !ctrl_r[CTRL_OSC_RUN]) begin
          gate_nxt = 1'b0;
          timer_nxt = T_HOLD;
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (timer_r == '0) begin
          state_nxt = ST_PD;
        end
      end
      ST_PD: begin
        // Gate held low until software withdraws the request
        if (!ctrl_r[CTRL_PD_REQ]) begin
          timer_nxt = T_CLK_PRE;
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (timer_r == '0) begin
          gate_nxt = 1'b1;
          timer_nxt = T_EXIT;
          state_nxt = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (timer_r == '0) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    // Registered so the device reset pin cannot glitch
    rstn_nxt = ~ctrl_nxt[CTRL_DRAM_RESET];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_RUN;
      timer_r <= '0;
      div_r <= '0;
      ck_r <= 1'b0;
      gate_r <= 1'b1;
      sel_r <= 1'b0;
      ca_r <= '0;
      ctrl_r <= '0;
      pend_r <= 1'b0;
      pend_mrr_r <= 1'b0;
      sent_mrr_r <= 1'b0;
      pend_ca_r <= '0;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rstn_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      div_r <= div_nxt;
      ck_r <= ck_nxt;
      gate_r <= gate_nxt;
      sel_r <= sel_nxt;
      ca_r <= ca_nxt;
      ctrl_r <= ctrl_nxt;
      pend_r <= pend_nxt;
      pend_mrr_r <= pend_mrr_nxt;
      sent_mrr_r <= sent_mrr_nxt;
      pend_ca_r <= pend_ca_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      rstn_r <= rstn_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign link.gate = gate_r;
  assign link.sel = sel_r;
  assign link.ca = ca_r;
  assign link.ck = ck_r;
  assign link.reset_n = rstn_r;
endmodule : pd_controller

// ==== rtl/pd_dram.sv ====
// Device end: power-down state, kind, buffers, termination and single-ended modes
`timescale 1ns/100ps
module pd_dram import pd_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  pd_link_if.dram link,
  input wire logic banks_open,
  input wire logic self_refresh_active,
  input wire logic ops_busy,
  input wire logic vddq_ok,
  input wire logic [7:0] termination_value,
  input wire logic [7:0] single_ended_mode_value,
  output logic in_power_down,
  output logic [1:0] pd_kind,
  output logic buffers_on,
  output logic low_current,
  output logic refresh_on,
  output logic cmd_term_on,
  output logic se_clock,
  output logic se_wstrobe,
  output logic se_rstrobe,
  output logic cmd_valid,
  output logic [CA_W-1:0] cmd_ca
);
  typedef enum logic [1:0] {
    ST_ON = 2'b01,
    ST_DOWN = 2'b10
  } dram_state_t;

  // ============================================================
  // Pin synchronisers, two stages before any logic
  logic [CA_W+3:0] pin_s1_r, pin_s2_r;
  logic ck_s3_r;
  logic gate_s, sel_s, ck_s, rstn_s;
  logic [CA_W-1:0] ca_s;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= {link.reset_n, link.gate, link.sel, link.ck, link.ca};
      pin_s2_r <= pin_s1_r;
      ck_s3_r <= pin_s2_r[CA_W];
    end
  end
  assign {rstn_s, gate_s, sel_s, ck_s, ca_s} = pin_s2_r;

  // ============================================================
  // Power-down state and outputs
  dram_state_t state_r, state_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic valid_r, valid_nxt;
  logic [CA_W-1:0] ca_r, ca_nxt;
  logic term_r, term_nxt;
  logic [2:0] se_r, se_nxt;
  logic lowi_r, lowi_nxt;
  logic refr_r, refr_nxt;
  logic down_r, down_nxt;
  logic on_r, on_nxt;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    valid_nxt = 1'b0;
    ca_nxt = ca_r;
    // Termination independent of power-down
    term_nxt = (termination_value[TERM_MSB:TERM_LSB] != 3'h0) && vddq_ok;
    se_nxt = {single_ended_mode_value[SE_CLOCK_BIT], single_ended_mode_value[SE_WSTROBE_BIT],
              single_ended_mode_value[SE_RSTROBE_BIT]};
    if (!rstn_s) begin
      // Reset pin stays live in every state
      state_nxt = ST_ON;
      kind_nxt = PD_IDLE;
    end else begin
      case (state_r)
        ST_ON: begin
          if (!gate_s) begin
            state_nxt = ST_DOWN;
            kind_nxt = self_refresh_active ? PD_SELF_REFRESH : (banks_open ? PD_ACTIVE : PD_IDLE);
          end else if (ck_s && !ck_s3_r && sel_s) begin
            valid_nxt = 1'b1;
            ca_nxt = ca_s;
          end
        end
        ST_DOWN: begin
          // Select, command and clock are not looked at here
          if (gate_s) begin
            state_nxt = ST_ON;
          end
        end
        default: state_nxt = ST_ON;
      endcase
    end
    // Low current only once in-flight row work finishes
    lowi_nxt = (state_nxt == ST_DOWN) && !ops_busy;
    // Refresh stops in power-down unless entered from self refresh
    refr_nxt = self_refresh_active && ((state_nxt == ST_ON) || (kind_nxt == PD_SELF_REFRESH));
    down_nxt = (state_nxt == ST_DOWN);
    on_nxt = (state_nxt == ST_ON);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= ST_ON;
      kind_r <= PD_IDLE;
      valid_r <= 1'b0;
      ca_r <= '0;
      term_r <= 1'b0;
      se_r <= 3'h0;
      lowi_r <= 1'b0;
      refr_r <= 1'b0;
      down_r <= 1'b0;
      on_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      valid_r <= valid_nxt;
      ca_r <= ca_nxt;
      term_r <= term_nxt;
      se_r <= se_nxt;
      lowi_r <= lowi_nxt;
      refr_r <= refr_nxt;
      down_r <= down_nxt;
      on_r <= on_nxt;
    end
  end

  assign in_power_down = down_r;
  assign buffers_on = on_r;
  assign pd_kind = kind_r;
  assign low_current = lowi_r;
  assign refresh_on = refr_r;
  assign cmd_term_on = term_r;
  assign {se_clock, se_wstrobe, se_rstrobe} = se_r;
  assign cmd_valid = valid_r;
  assign cmd_ca = ca_r;
endmodule : pd_dram

// ==== bench/pd_link_chk.sv ====
// Checker for the power-down gate link between controller and device
`timescale 1ns/100ps
module pd_link_chk import pd_pkg::*; #(
  parameter int CK_HALF = CK_HALF_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic gate,
  input wire logic sel,
  input wire logic [CA_W-1:0] ca,
  input wire logic ck,
  input wire logic reset_n
);
  // ============================================================
  // Link timing in sys cycles; the link-cycle term dominates here
  localparam int TCK = 2 * CK_HALF;
  localparam int MIN_P = MIN_PULSE_NCK * TCK;
  localparam int CK_HOLD = CLOCK_HOLD_NCK * TCK;
  localparam int EXIT = EXIT_LAT_NCK * TCK;
  localparam int CK_PRE = CLOCK_PRE_NCK * TCK;
  localparam int CMD_GAP = CMD_TO_GATE_NCK * TCK;
  logic [11:0] lo_r, lo_nxt, hi_r, hi_nxt, same_r, same_nxt, run_r, run_nxt, cmd_r, cmd_nxt;
  logic ck_q_r, sel_q_r;

  // Saturating, so a long residency never wraps into a false short one
  function automatic logic [11:0] inc(input logic [11:0] v);
    inc = (v == 12'hfff) ? v : v + 12'h001;
  endfunction : inc

  // ============================================================
  // Helper counters
  always_comb begin
    lo_nxt = gate ? 12'h000 : inc(lo_r);
    hi_nxt = gate ? inc(hi_r) : 12'h000;
    same_nxt = (ck == ck_q_r) ? inc(same_r) : 12'h000;
    run_nxt = (same_r < CK_HALF) ? inc(run_r) : 12'h000;
    cmd_nxt = (sel && !sel_q_r) ? 12'h000 : inc(cmd_r);
  end

  // Reset leaves gate high long ago, so the first entry is not judged short
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lo_r <= 12'h000;
      hi_r <= 12'hfff;
      same_r <= 12'h000;
      run_r <= 12'h000;
      cmd_r <= 12'hfff;
      ck_q_r <= 1'b0;
      sel_q_r <= 1'b0;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      same_r <= same_nxt;
      run_r <= run_nxt;
      cmd_r <= cmd_nxt;
      ck_q_r <= ck;
      sel_q_r <= sel;
    end
  end

  // ============================================================
  // Assertions
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sel_low_a: assert property (!gate |-> !sel)
    else $error("Select high while gate low");
  ck_hold_a: assert property ((!gate && lo_r < CK_HOLD - TCK) |-> same_r < CK_HALF)
    else $error("Clock stopped inside clock hold");
  low_width_a: assert property ($rose(gate) |-> lo_r >= MIN_P)
    else $error("Gate low pulse too short");
  high_width_a: assert property ($fell(gate) |-> hi_r >= MIN_P)
    else $error("Gate high pulse too short");
  exit_cmd_a: assert property ((gate && hi_r < EXIT) |-> !sel)
    else $error("Command inside exit latency");
  ck_pre_a: assert property ($rose(gate) |-> run_r >= CK_PRE - TCK)
    else $error("Clock not running before gate high");
  cmd_gap_a: assert property ($fell(gate) |-> cmd_r >= CMD_GAP)
    else $error("Gate low too soon after command");
  ck_stop_a: assert property ((same_r > 2 * TCK) |-> !gate)
    else $error("Clock stopped while gate high");
endmodule : pd_link_chk

// ==== bench/dram_power_down_control_tb.sv ====
// Testbench: controller and device joined over the gate link
`timescale 1ns/100ps
module dram_power_down_control_tb import pd_pkg::*;;
  localparam int CKH = 2;
  localparam int TCK = 2 * CKH;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic banks_open = 1'b0;
  logic self_refresh_active = 1'b0;
  logic ops_busy = 1'b0;
  logic vddq_ok = 1'b1;
  logic [7:0] termination_value = 8'h00;
  logic [7:0] single_ended_mode_value = 8'h00;
  logic in_power_down, buffers_on, low_current, refresh_on, cmd_term_on;
  logic se_clock, se_wstrobe, se_rstrobe, cmd_valid, sel_q;
  logic [1:0] pd_kind;
  logic [CA_W-1:0] cmd_ca;
  logic [31:0] rd_q[$];
  logic [CA_W-1:0] cmd_q[$];
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int sel_at = 0;

  pd_link_if link();
  pd_controller #(.CK_HALF(CKH)) pd_controller_inst (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  pd_dram pd_dram_inst (.sys_clk(sys_clk), .reset(reset), .link(link), .banks_open(banks_open),
    .self_refresh_active(self_refresh_active), .ops_busy(ops_busy), .vddq_ok(vddq_ok),
    .termination_value(termination_value), .single_ended_mode_value(single_ended_mode_value),
    .in_power_down(in_power_down), .pd_kind(pd_kind), .buffers_on(buffers_on), .low_current(low_current),
    .refresh_on(refresh_on), .cmd_term_on(cmd_term_on), .se_clock(se_clock), .se_wstrobe(se_wstrobe),
    .se_rstrobe(se_rstrobe), .cmd_valid(cmd_valid), .cmd_ca(cmd_ca));
  pd_link_chk #(.CK_HALF(CKH)) pd_link_chk_inst (.sys_clk(sys_clk), .reset(reset), .gate(link.gate),
    .sel(link.sel), .ca(link.ca), .ck(link.ck), .reset_n(link.reset_n));

  always #2.5 sys_clk = ~sys_clk;

  // ============================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Request held until waitrequest is sampled low, released after that edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : av

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    av(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Kind 0 power-down flag, 1 gate, 2 command queue drained
  task automatic wait_until(input int w, input logic v);
    int n;
    n = 0;
    while (((w == 0) ? in_power_down : (w == 1) ? link.gate : logic'(cmd_q.size() == 0)) !== v && n < 800) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(n < 800), 32'h0000_0001);
  endtask : wait_until

  task automatic send_cmd(input logic [31:0] d);
    cmd_q.push_back(d[CA_W-1:0]);
    av(1'b1, REG_CMD, d);
  endtask : send_cmd

  // ============================================================
  // Result watcher
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    sel_q <= link.sel;
    if (link.sel === 1'b1 && sel_q === 1'b0) sel_at <= cyc;
    if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, rd_q.pop_front());
    if (cmd_valid === 1'b1) check(32'(cmd_ca), (cmd_q.size() > 0) ? 32'(cmd_q.pop_front()) : 32'hffff_ffff);
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  // ============================================================
  // Main sequence
  initial begin
    int i;
    int k;
    int gap0;
    void'($urandom(32'h0000_8036));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(REG_STATUS, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    av(1'b1, REG_CTRL, 32'h0000_0004);
    rd(REG_CTRL, 32'h0000_0004);
    for (i = 0; i < 3; i++) send_cmd(32'($urandom) & 32'h0000_003f);
    wait_until(2, 1'b1);
    // Entry must wait for a busy operation or a running oscillator
    for (i = CTRL_OP_BUSY; i <= CTRL_OSC_RUN; i++) begin
      av(1'b1, REG_CTRL, 32'h0000_0001 | (32'h0000_0001 << i));
      repeat (60) @(posedge sys_clk);
      check(32'(link.gate), 32'h0000_0001);
    end
    for (k = 0; k < 3; k++) begin
      banks_open <= (k == 1);
      self_refresh_active <= (k == 2);
      ops_busy <= (k == 1);
      vddq_ok <= (k != 1);
      termination_value <= 8'($urandom);
      av(1'b1, REG_CTRL, 32'h0000_0001);
      wait_until(0, 1'b1);
      @(posedge sys_clk);
      check(32'(pd_kind), 32'(k));
      check(32'(buffers_on), 32'h0000_0000);
      check(32'(refresh_on), 32'(k == 2));
      check(32'(cmd_term_on), 32'((termination_value[TERM_MSB:TERM_LSB] != 3'h0) && k != 1));
      check(32'(low_current), 32'(k != 1));
      // Controller reports settled power-down only after the entry hold
      repeat (CLOCK_HOLD_NCK * TCK) @(posedge sys_clk);
      rd(REG_STATUS, 32'h0000_0003);
      ops_busy <= 1'b0;
      self_refresh_active <= (k != 1);
      repeat (2) @(posedge sys_clk);
      check(32'(low_current), 32'h0000_0001);
      check(32'(refresh_on), 32'(k == 2));
      av(1'b1, REG_CTRL, 32'h0000_0000);
      wait_until(0, 1'b0);
      check(32'(buffers_on), 32'h0000_0001);
      self_refresh_active <= 1'b0;
      send_cmd(32'($urandom) & 32'h0000_003f);
      rd(REG_STATUS, 32'h0000_000c);
    end
    wait_until(2, 1'b1);
    // Mode register read, then entry, with short and long postamble
    for (k = 0; k < 2; k++) begin
      send_cmd(32'h0000_0100);
      av(1'b1, REG_CTRL, (32'(k) << CTRL_LONG_POST) | 32'h0000_0001);
      wait_until(1, 1'b0);
      check(32'((cyc - sel_at) >= (6 + 8 + 1 + k) * TCK + 1), 32'h0000_0001);
      check(32'((cyc - sel_at) >= gap0 + k * TCK), 32'h0000_0001);
      gap0 = cyc - sel_at;
      av(1'b1, REG_CTRL, 32'h0000_0000);
      wait_until(1, 1'b1);
    end
    // Device reset pin stays live in power-down
    banks_open <= 1'b1;
    av(1'b1, REG_CTRL, 32'h0000_0001);
    wait_until(0, 1'b1);
    av(1'b1, REG_CTRL, 32'h0000_0003);
    wait_until(0, 1'b0);
    check(32'(pd_kind), 32'(PD_IDLE));
    check(32'(buffers_on), 32'h0000_0001);
    av(1'b1, REG_CTRL, 32'h0000_0001);
    wait_until(0, 1'b1);
    check(32'(pd_kind), 32'(PD_ACTIVE));
    banks_open <= 1'b0;
    av(1'b1, REG_CTRL, 32'h0000_0000);
    wait_until(1, 1'b1);
    for (k = 0; k < 8; k++) begin
      single_ended_mode_value <= (8'($urandom) & 8'hf1) | {4'h0, k[2:0], 1'b0};
      repeat (2) @(posedge sys_clk);
      check(32'({se_clock, se_wstrobe, se_rstrobe}), 32'(k[2:0]));
    end
    wait_until(2, 1'b1);
    close_out();
  end
endmodule : dram_power_down_control_tb
